// ==== rtl/pmw_ctrl.sv ====
`timescale 1ns/1ps
module pmw_ctrl (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_req,
  input wire logic clr_wdt,
  input wire logic wdt_on,
  input wire logic wdt_overflow,
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_en,
  input wire logic stack_full,
  input wire logic [7:0] port_a_pin,
  output logic sysclk_en_r,
  output logic tbc_en_r,
  output logic lsrc_en_r,
  output logic hosc_en_r,
  output logic clk_low_r,
  output logic [2:0] clk_div_log2_r,
  output logic wdt_clr_r,
  output logic wdt_hold_r,
  output logic cpu_halt_r,
  output logic resume_r,
  output logic irq_take_r,
  output logic pcsp_rst_r
);
  // ==========================================================
  // decode shared by read and write paths
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    if (a == pmw_pkg::ADDR_MODE)
      reg_idx = pmw_pkg::IDX_MODE;
    else if (a == pmw_pkg::ADDR_IDLE)
      reg_idx = pmw_pkg::IDX_IDLE;
    else if (a == pmw_pkg::ADDR_PWE)
      reg_idx = pmw_pkg::IDX_PWE;
    else if (a == pmw_pkg::ADDR_STAT)
      reg_idx = pmw_pkg::IDX_STAT;
    else
      reg_idx = pmw_pkg::IDX_NONE;
  endfunction

  pmw_pkg::pmw_state_t st_r, st_nxt;
  pmw_pkg::pmw_wake_t kind_r, kind_nxt;
  logic [2:0] div_sel_r;
  logic fast_r, ioh_r, syson_r, srf_r, lowv_r, wcrf_r;
  logic [7:0] pwe_r;
  logic pd_r, to_r;
  logic [7:0] irq_armed_r;
  logic [5:0] lcnt_r, hcnt_r;
  logic lrdy_r, hrdy_r;
  logic [7:0] pin_fall;
  logic aw_have_r, w_have_r;
  logic [7:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;

  pmw_pin_wake u_pin (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(port_a_pin),
    .fall_r(pin_fall)
  );

  // ==========================================================
  // bus slave
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire do_wr = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [2:0] widx = reg_idx(awaddr_r);
  wire [2:0] ridx = reg_idx(s_axi_araddr);
  wire wr_en = do_wr & wstrb0_r;
  wire wr_mode = wr_en & (widx == pmw_pkg::IDX_MODE);
  wire wr_idle = wr_en & (widx == pmw_pkg::IDX_IDLE);
  wire wr_pwe = wr_en & (widx == pmw_pkg::IDX_PWE);
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (ridx == pmw_pkg::IDX_MODE)
      rd_byte = {div_sel_r, 1'b0, lrdy_r, hrdy_r, ioh_r, fast_r};
    else if (ridx == pmw_pkg::IDX_IDLE)
      rd_byte = {syson_r, 3'h0, srf_r, lowv_r, 1'b0, wcrf_r};
    else if (ridx == pmw_pkg::IDX_PWE)
      rd_byte = pwe_r;
    else if (ridx == pmw_pkg::IDX_STAT)
      rd_byte = {st_r, pd_r, to_r};
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmw_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        s_axi_awready <= 1'b0;
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_have_r <= 1'b0;
      else if (b_hs)
        s_axi_awready <= 1'b1;
      if (w_hs)
      begin
        s_axi_wready <= 1'b0;
        w_have_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      else if (do_wr)
        w_have_r <= 1'b0;
      else if (b_hs)
        s_axi_wready <= 1'b1;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx == pmw_pkg::IDX_NONE) ? pmw_pkg::RESP_SLVERR
                                                    : pmw_pkg::RESP_OKAY;
      end
      else if (b_hs)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmw_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= (ridx == pmw_pkg::IDX_NONE) ? pmw_pkg::RESP_SLVERR
                                                  : pmw_pkg::RESP_OKAY;
    end
    else if (r_hs)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_sel_r <= pmw_pkg::DIV_RST;
      fast_r <= pmw_pkg::FAST_RST;
      ioh_r <= pmw_pkg::IOH_RST;
      syson_r <= pmw_pkg::SYSON_RST;
      srf_r <= 1'b0;
      lowv_r <= 1'b0;
      wcrf_r <= 1'b0;
      pwe_r <= pmw_pkg::PWE_RST;
    end
    else
    begin
      if (wr_mode)
      begin
        div_sel_r <= wbyte_r[pmw_pkg::MODE_DIV_LSB +: 3];
        fast_r <= wbyte_r[pmw_pkg::MODE_FAST_BIT];
        ioh_r <= wbyte_r[pmw_pkg::MODE_IOH_BIT];
      end
      if (wr_idle)
      begin
        syson_r <= wbyte_r[pmw_pkg::IDLE_SYSON_BIT];
        srf_r <= wbyte_r[pmw_pkg::IDLE_SRF_BIT];
        lowv_r <= wbyte_r[pmw_pkg::IDLE_LOWV_BIT];
        wcrf_r <= wbyte_r[pmw_pkg::IDLE_WCRF_BIT];
      end
      if (wr_pwe)
        pwe_r <= wbyte_r;
    end
  end

  // ==========================================================
  // clock selection
  // slow is only taken once the low oscillator reports ready
  wire slow_req = ~fast_r & (div_sel_r <= pmw_pkg::DIV_LOW_MAX);
  wire slow_nxt = slow_req & (clk_low_r | lrdy_r);
  wire [2:0] div_exp = fast_r ? 3'h0 : 3'(pmw_pkg::DIV_EXP_BASE - {1'b0, div_sel_r});

  // ==========================================================
  // power state machine
  wire in_low = (st_r == pmw_pkg::ST_DEEP) | (st_r == pmw_pkg::ST_LIGHT) |
                (st_r == pmw_pkg::ST_IDLE_OFF) | (st_r == pmw_pkg::ST_IDLE_ON);
  wire halt_go = (st_r == pmw_pkg::ST_RUN) & halt_req;
  wire [7:0] irq_new = irq_req & irq_armed_r;
  wire port_wake = |(pin_fall & pwe_r);
  wire irq_wake = |irq_new;
  wire irq_serve = |(irq_new & irq_en) & ~stack_full;
  wire wake_any = wdt_overflow | irq_wake | port_wake;

  always_comb
  begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    case (st_r)
      pmw_pkg::ST_RUN:
      begin
        if (halt_req)
        begin
          if (!ioh_r)
            st_nxt = wdt_on ? pmw_pkg::ST_LIGHT : pmw_pkg::ST_DEEP;
          else
            st_nxt = syson_r ? pmw_pkg::ST_IDLE_ON : pmw_pkg::ST_IDLE_OFF;
        end
      end
      pmw_pkg::ST_DEEP, pmw_pkg::ST_LIGHT, pmw_pkg::ST_IDLE_OFF, pmw_pkg::ST_IDLE_ON:
      begin
        if (wake_any)
        begin
          st_nxt = pmw_pkg::ST_WAKE;
          if (wdt_overflow)
            kind_nxt = pmw_pkg::WK_WDT;
          else if (irq_wake && irq_serve)
            kind_nxt = pmw_pkg::WK_IRQ;
          else
            kind_nxt = pmw_pkg::WK_RESUME;
        end
      end
      pmw_pkg::ST_WAKE:
      begin
        // clocks restart first; execution resumes once low osc is stable
        if (lrdy_r)
          st_nxt = pmw_pkg::ST_RUN;
      end
      default:
        st_nxt = pmw_pkg::ST_RUN;
    endcase
  end

  wire run_nxt = st_nxt == pmw_pkg::ST_RUN;
  wire wake_nxt = st_nxt == pmw_pkg::ST_WAKE;
  wire ion_nxt = st_nxt == pmw_pkg::ST_IDLE_ON;
  wire ioff_nxt = st_nxt == pmw_pkg::ST_IDLE_OFF;
  wire leave = (st_r == pmw_pkg::ST_WAKE) & lrdy_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= pmw_pkg::ST_RUN;
      kind_r <= pmw_pkg::WK_RESUME;
      sysclk_en_r <= 1'b1;
      tbc_en_r <= 1'b1;
      lsrc_en_r <= 1'b1;
      hosc_en_r <= 1'b1;
      clk_low_r <= 1'b0;
      clk_div_log2_r <= 3'h0;
      wdt_clr_r <= 1'b0;
      wdt_hold_r <= 1'b0;
      cpu_halt_r <= 1'b0;
      resume_r <= 1'b0;
      irq_take_r <= 1'b0;
      pcsp_rst_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      sysclk_en_r <= run_nxt | wake_nxt | ion_nxt;
      tbc_en_r <= run_nxt | wake_nxt | ion_nxt | ioff_nxt;
      lsrc_en_r <= st_nxt != pmw_pkg::ST_DEEP;
      hosc_en_r <= ~slow_nxt & (run_nxt | wake_nxt | ion_nxt);
      clk_low_r <= slow_nxt;
      if (!slow_req)
        clk_div_log2_r <= div_exp;
      wdt_clr_r <= halt_go;
      wdt_hold_r <= st_nxt == pmw_pkg::ST_DEEP;
      cpu_halt_r <= ~run_nxt;
      resume_r <= leave & (kind_r == pmw_pkg::WK_RESUME);
      irq_take_r <= leave & (kind_r == pmw_pkg::WK_IRQ);
      pcsp_rst_r <= leave & (kind_r == pmw_pkg::WK_WDT);
    end
  end

  // ==========================================================
  // flags, interrupt arming, oscillator ready
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pd_r <= 1'b0;
      to_r <= 1'b0;
      irq_armed_r <= 8'h00;
    end
    else
    begin
      // set wins over clear on both flags
      if (halt_go)
        pd_r <= 1'b1;
      else if (clr_wdt)
        pd_r <= 1'b0;
      if (wdt_overflow)
        to_r <= 1'b1;
      else if (halt_go)
        to_r <= 1'b0;
      if (halt_go)
        irq_armed_r <= ~irq_req;
      else if (in_low)
        irq_armed_r <= irq_armed_r | ~irq_req;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lcnt_r <= 6'h00;
      hcnt_r <= 6'h00;
      lrdy_r <= 1'b0;
      hrdy_r <= 1'b0;
    end
    else
    begin
      lcnt_r <= !lsrc_en_r ? 6'h00 : (lrdy_r ? lcnt_r : 6'(lcnt_r + 6'h01));
      // flag register adds a cycle, so compare one short to rise two cycles after enable
      lrdy_r <= lsrc_en_r & (lcnt_r >= 6'(pmw_pkg::LOSC_RDY_CYC - 6'h01));
      hcnt_r <= !hosc_en_r ? 6'h00 : (hrdy_r ? hcnt_r : 6'(hcnt_r + 6'h01));
      hrdy_r <= hosc_en_r & (hcnt_r >= pmw_pkg::HOSC_STAB_CYC);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_deep_entry: assert property (halt_go && !ioh_r && !wdt_on |=>
    st_r == pmw_pkg::ST_DEEP && !sysclk_en_r && !lsrc_en_r && wdt_hold_r && wdt_clr_r)
    else $error("deep sleep entry wrong");
  a_light_entry: assert property (halt_go && !ioh_r && wdt_on |=>
    st_r == pmw_pkg::ST_LIGHT && !sysclk_en_r && !tbc_en_r && lsrc_en_r)
    else $error("light sleep entry wrong");
  a_idle_off_entry: assert property (halt_go && ioh_r && !syson_r |=>
    st_r == pmw_pkg::ST_IDLE_OFF && !sysclk_en_r && tbc_en_r)
    else $error("idle-off entry wrong");
  a_idle_on_entry: assert property (halt_go && ioh_r && syson_r |=>
    st_r == pmw_pkg::ST_IDLE_ON && sysclk_en_r && tbc_en_r && cpu_halt_r)
    else $error("idle-on entry wrong");
  a_halt_flags: assert property (halt_go && !wdt_overflow |=> pd_r && !to_r)
    else $error("halt flags wrong");
  a_slow_waits: assert property (slow_req && !lrdy_r && !clk_low_r |=> !clk_low_r)
    else $error("slow switch before ready");
  a_fast_undiv: assert property (fast_r |=> clk_div_log2_r == 3'h0 && !clk_low_r)
    else $error("fast select not undivided");
  a_hosc_stops: assert property (clk_low_r |-> !hosc_en_r)
    else $error("high osc runs in slow");
  a_lrdy_deep: assert property ($past(st_r) == pmw_pkg::ST_DEEP && st_r == pmw_pkg::ST_DEEP
    |-> !lrdy_r)
    else $error("low osc ready in deep sleep");
  a_lrdy_wake: assert property ($rose(lsrc_en_r) |-> ##2 lrdy_r)
    else $error("low osc ready late after wake");
  a_wdt_wake: assert property (leave && kind_r == pmw_pkg::WK_WDT |=>
    pcsp_rst_r && !resume_r && !irq_take_r)
    else $error("watchdog wake action wrong");

  c_deep: cover property (halt_go && !ioh_r && !wdt_on);
  c_irq_take: cover property (irq_take_r);
  c_port_resume: cover property (in_low && port_wake ##[1:8] resume_r);
endmodule // pmw_ctrl

// ==== include/pmw_pkg.sv ====
// ==========================================================
// power mode wake controller constants
package pmw_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_IDLE = 8'h04;
  localparam logic [7:0] ADDR_PWE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_IDLE = 3'h1;
  localparam logic [2:0] IDX_PWE = 3'h2;
  localparam logic [2:0] IDX_STAT = 3'h3;
  localparam logic [2:0] IDX_NONE = 3'h7;
  // ==========================================================
  // field positions
  localparam int MODE_FAST_BIT = 0;
  localparam int MODE_IOH_BIT = 1;
  localparam int MODE_HRDY_BIT = 2;
  localparam int MODE_LRDY_BIT = 3;
  localparam int MODE_DIV_LSB = 5;
  localparam int IDLE_SYSON_BIT = 7;
  localparam int IDLE_SRF_BIT = 3;
  localparam int IDLE_LOWV_BIT = 2;
  localparam int IDLE_WCRF_BIT = 0;
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_ST_LSB = 2;
  // ==========================================================
  // values after reset and divider limits
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic FAST_RST = 1'h1;
  localparam logic IOH_RST = 1'h1;
  localparam logic SYSON_RST = 1'h0;
  localparam logic [7:0] PWE_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'hFF;
  localparam logic [2:0] DIV_LOW_MAX = 3'h1;
  localparam logic [3:0] DIV_EXP_BASE = 4'h8;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOSC_STAB_NS = 1000;
  localparam logic [5:0] HOSC_STAB_CYC =
    6'((HOSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] LOSC_RDY_CYC = 6'h02;
  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_DEEP = 6'h02,
    ST_LIGHT = 6'h04,
    ST_IDLE_OFF = 6'h08,
    ST_IDLE_ON = 6'h10,
    ST_WAKE = 6'h20
  } pmw_state_t;
  typedef enum logic [1:0] {
    WK_RESUME = 2'h0,
    WK_IRQ = 2'h1,
    WK_WDT = 2'h2
  } pmw_wake_t;
endpackage

// ==== rtl/pmw_pin_wake.sv ====
`timescale 1ns/1ps
// ==========================================================
// port pin synchroniser and falling edge detect
module pmw_pin_wake (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] pin,
  output logic [7:0] fall_r
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  // idle-high pins, so reset to high to avoid a false edge
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= pmw_pkg::PIN_RST;
      s2_r <= pmw_pkg::PIN_RST;
      s3_r <= pmw_pkg::PIN_RST;
      fall_r <= 8'h00;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      fall_r <= s3_r & ~s2_r;
    end
  end
endmodule // pmw_pin_wake

// ==== testbench/pmw_partner.sv ====
`timescale 1ns/1ps
// ==========================================================
// cpu core, interrupt logic and port pin model
module pmw_partner (
  input wire logic core_clk,
  output logic halt_req,
  output logic clr_wdt,
  output logic wdt_on,
  output logic wdt_overflow,
  output logic [7:0] irq_req,
  output logic [7:0] irq_en,
  output logic stack_full,
  output logic [7:0] port_a_pin
);
  // pins idle high so that only a commanded fall can wake
  initial
  begin
    halt_req = 1'b0;
    clr_wdt = 1'b0;
    wdt_on = 1'b0;
    wdt_overflow = 1'b0;
    irq_req = 8'h00;
    irq_en = 8'h00;
    stack_full = 1'b0;
    port_a_pin = 8'hFF;
  end
  // ==========================================================
  // one cycle instruction pulses and a port pin fall
  task automatic halt();
    @(posedge core_clk);
    halt_req <= 1'b1;
    @(posedge core_clk);
    halt_req <= 1'b0;
  endtask
  task automatic ovf();
    @(posedge core_clk);
    wdt_overflow <= 1'b1;
    @(posedge core_clk);
    wdt_overflow <= 1'b0;
  endtask
  task automatic clr();
    @(posedge core_clk);
    clr_wdt <= 1'b1;
    @(posedge core_clk);
    clr_wdt <= 1'b0;
  endtask
  task automatic pin_fall(input int k);
    @(posedge core_clk);
    port_a_pin[k] <= 1'b0;
  endtask
endmodule // pmw_partner

// ==== testbench/power_mode_wake_controller_bench.sv ====
`timescale 1ns/1ps
// ==========================================================
// power mode wake controller bench
module power_mode_wake_controller_bench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic awr, wrd, bv, arr, rv, halt_req, clr_wdt, wdt_on, wdt_ovf, stack_full;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [7:0] irq_req, irq_en, pins;
  logic sys_en, tbc_en, lsrc_en, hosc_en, clk_low, wclr, whold, cpu_halt, resume, take, pcsp;
  logic [2:0] div;
  int error_cnt = 0;
  int samples_checked = 0;
  always #20 core_clk = ~core_clk;
  pmw_partner p (.core_clk(core_clk), .halt_req(halt_req), .clr_wdt(clr_wdt),
    .wdt_on(wdt_on), .wdt_overflow(wdt_ovf), .irq_req(irq_req), .irq_en(irq_en),
    .stack_full(stack_full), .port_a_pin(pins));
  pmw_ctrl dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .halt_req(halt_req),
    .clr_wdt(clr_wdt), .wdt_on(wdt_on), .wdt_overflow(wdt_ovf), .irq_req(irq_req),
    .irq_en(irq_en), .stack_full(stack_full), .port_a_pin(pins), .sysclk_en_r(sys_en),
    .tbc_en_r(tbc_en), .lsrc_en_r(lsrc_en), .hosc_en_r(hosc_en), .clk_low_r(clk_low),
    .clk_div_log2_r(div), .wdt_clr_r(wclr), .wdt_hold_r(whold), .cpu_halt_r(cpu_halt),
    .resume_r(resume), .irq_take_r(take), .pcsp_rst_r(pcsp));
  // ==========================================================
  // compare, bus and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arr === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    d = rdat;
    chk({30'h0, rr}, {30'h0, pmw_pkg::RESP_OKAY});
    rry <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // expectations: {sysclk, timebase, low rc, wdt hold} and pulses {pcsp, irq, resume}
  function automatic logic [3:0] exp_en(input int m);
    return (m == 0) ? 4'h1 : (m == 1) ? 4'h2 : (m == 2) ? 4'h6 : 4'hE;
  endfunction
  function automatic logic [5:0] exp_st(input int m);
    return (m == 0) ? pmw_pkg::ST_DEEP : (m == 1) ? pmw_pkg::ST_LIGHT :
      (m == 2) ? pmw_pkg::ST_IDLE_OFF : pmw_pkg::ST_IDLE_ON;
  endfunction
  function automatic logic [2:0] exp_pulse(input int s);
    return (s == 1) ? 3'h4 : (s == 2) ? 3'h2 : 3'h1;
  endfunction
  // run is under a thousand cycles; the limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic [2:0] seen;
    int dv, m, k, j, w;
    void'($urandom(32'h587BCD89));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (40) @(posedge core_clk);
    rchk(pmw_pkg::ADDR_MODE, 32'hFF, 32'h0F);
    rchk(pmw_pkg::ADDR_IDLE, 32'hFF, 32'h00);
    rchk(pmw_pkg::ADDR_PWE, 32'hFF, 32'h00);
    rchk(pmw_pkg::ADDR_STAT, 32'hFF, {24'h0, pmw_pkg::ST_RUN, 2'b00});
    wr(8'h10, 32'hFF, r);
    chk({30'h0, r}, {30'h0, pmw_pkg::RESP_SLVERR});
    wr(pmw_pkg::ADDR_IDLE, 32'hFF, r);
    rchk(pmw_pkg::ADDR_IDLE, 32'hFFFFFFFF, 32'h8D);
    wr(pmw_pkg::ADDR_IDLE, 32'h00, r);
    $display("test registers done");
    for (int i = 0; i < 10; i++)
    begin
      dv = (i < 8) ? i : $urandom % 8;
      wr(pmw_pkg::ADDR_MODE, {24'h0, 3'(dv), 5'h02}, r);
      repeat (8) @(posedge core_clk);
      #1;
      chk({31'h0, clk_low}, {31'h0, dv < 2});
      chk({31'h0, hosc_en}, {31'h0, dv >= 2});
      if (dv >= 2) chk({29'h0, div}, 32'(8 - dv));
      wr(pmw_pkg::ADDR_MODE, 32'h03, r);
      do rd(pmw_pkg::ADDR_MODE, d); while (d[pmw_pkg::MODE_HRDY_BIT] !== 1'b1);
      chk({28'h0, clk_low, div}, 32'h0);
    end
    $display("test clock select done");
    for (int c = 0; c < 5; c++)
    begin
      m = (c == 4) ? 0 : c;
      k = $urandom % 8;
      j = $urandom % 8;
      w = j ^ 1;
      wr(pmw_pkg::ADDR_MODE, {30'h0, m[1], 1'b1}, r);
      wr(pmw_pkg::ADDR_IDLE, {24'h0, m[0], 7'h0}, r);
      wr(pmw_pkg::ADDR_PWE, 32'h1 << k, r);
      p.wdt_on <= (m != 0);
      p.irq_en <= (c == 2 || c == 4) ? 8'h01 << w : 8'h00;
      p.stack_full <= (c == 4);
      p.irq_req <= 8'h01 << j;
      p.halt();
      #1;
      chk({28'h0, sys_en, tbc_en, lsrc_en, whold}, exp_en(m));
      chk({30'h0, cpu_halt, wclr}, 32'h3);
      rchk(pmw_pkg::ADDR_STAT, 32'hFF, {24'h0, exp_st(m), 2'b10});
      if (m == 0) rchk(pmw_pkg::ADDR_MODE, 32'h08, 32'h00);
      p.pin_fall(k ^ 1);
      repeat (10) @(posedge core_clk);
      #1;
      chk({31'h0, cpu_halt}, 32'h1);
      if (c == 0) p.pin_fall(k);
      else if (c == 1) p.ovf();
      else p.irq_req[w] <= 1'b1;
      seen = 3'h0;
      repeat (30)
      begin
        @(posedge core_clk);
        #1;
        seen = seen | {pcsp, take, resume};
      end
      chk({29'h0, seen}, {29'h0, exp_pulse(c)});
      chk({31'h0, cpu_halt}, 32'h0);
      rchk(pmw_pkg::ADDR_STAT, 32'h03, {30'h0, 1'b1, c == 1});
      p.clr();
      rchk(pmw_pkg::ADDR_STAT, 32'h02, 32'h00);
      p.irq_req <= 8'h00;
      p.port_a_pin <= 8'hFF;
      repeat (6) @(posedge core_clk);
      $display("test low power case %0d done", c);
    end
    wrap_up();
  end
endmodule // power_mode_wake_controller_bench
